// ===== tb/rfat_bank_checker.sv
// Port-level assertions for the register field bank
`timescale 1ns/10ps
module rfat_bank_checker
   import rfat_pkg::*;
#(
   parameter int WIDTH = RFAT_FIELD_WIDTH
)
(
   // Clock and control
   input wire logic                             I_CLOCK,
   input wire logic                             I_NRST,
   input wire logic                             I_ENABLE,
   input wire logic                             I_SOFT_RESET,
   // Host port
   input wire logic [3:0]                       I_ADDR,
   input wire logic                             I_READ,
   input wire logic                             I_WRITE,
   input wire logic [WIDTH-1:0]                 I_WDATA,
   input wire logic [WIDTH-1:0]                 O_RDATA,
   // Hardware side
   input wire logic [WIDTH-1:0]                 I_HW_VALUE,
   input wire logic [WIDTH-1:0]                 I_HW_SET,
   input wire logic [RFAT_NUM_FIELDS*WIDTH-1:0] O_FIELDS
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   logic [WIDTH-1:0] f [RFAT_NUM_FIELDS];
   wire              run = I_ENABLE & !I_SOFT_RESET;
   wire              rd  = run & I_READ;
   wire              wr  = run & I_WRITE;
   for (genvar g = 0; g < RFAT_NUM_FIELDS; g++)
   begin : g_f
      assign f[g] = O_FIELDS[g*WIDTH+:WIDTH];
   end
   // Sticky bits that rose and have not been read since
   logic [WIDTH-1:0] prev9;
   logic [WIDTH-1:0] pend;
   wire  [WIDTH-1:0] rise9 = f[9] & ~prev9;
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         prev9 <= '0;
         pend  <= '0;
      end
      else if (I_ENABLE)
      begin
         prev9 <= f[9];
         pend  <= (I_SOFT_RESET || (I_READ && I_ADDR == 4'h9)) ? '0 : (pend | rise9);
      end
   end
   property p_ro; run |=> f[0] == $past(I_HW_VALUE); endproperty
   a_ro: assert property (p_ro) else $error("read-only field off");
   property p_sor; rd && I_ADDR == 4'h1 |=> &f[1]; endproperty
   a_sor: assert property (p_sor) else $error("set-on-read not set");
   property p_w1s; wr && I_ADDR == 4'h3 |=> f[3] == ($past(f[3]) | $past(I_WDATA)); endproperty
   a_w1s: assert property (p_w1s) else $error("write-one-set wrong");
   property p_w1c;
      wr && I_ADDR == 4'h4 |=> f[4] == (($past(f[4]) & ~$past(I_WDATA)) | $past(I_HW_SET));
   endproperty
   a_w1c: assert property (p_w1c) else $error("write-one-clear wrong");
   property p_wc; wr && I_ADDR == 4'h5 |=> f[5] == $past(I_HW_SET); endproperty
   a_wc: assert property (p_wc) else $error("write-any-clear wrong");
   property p_lh; rd && I_ADDR == 4'h7 |=> f[7] == $past(I_HW_SET); endproperty
   a_lh: assert property (p_lh) else $error("latch not cleared by read");
   // Auto-clear lasts one cycle only
   sequence s_sc_set; wr && I_ADDR == 4'h8 ##1 f[8] == $past(I_WDATA); endsequence
   property p_sc; s_sc_set ##0 (run && !(I_WRITE && I_ADDR == 4'h8)) |=> f[8] == '0; endproperty
   a_sc: assert property (p_sc) else $error("auto-clear bit stuck");
   property p_sticky;
      run && !(I_READ && I_ADDR == 4'h9) |=> f[9] == ($past(I_HW_VALUE) | $past(pend | rise9));
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky bit wrong");
   property p_sticky_rd; rd && I_ADDR == 4'h9 |=> f[9] == $past(I_HW_VALUE); endproperty
   a_sticky_rd: assert property (p_sticky_rd) else $error("read sticky bit wrong");
   property p_soft_reset_immune;
      I_ENABLE && I_SOFT_RESET && !(I_WRITE && I_ADDR == 4'hA) |=> $stable(f[10]) && f[3] == '0;
   endproperty
   a_soft_reset_immune: assert property (p_soft_reset_immune) else $error("soft reset handling wrong");
   property p_rdata; rd && I_ADDR == 4'h3 |=> O_RDATA == $past(f[3]); endproperty
   a_rdata: assert property (p_rdata) else $error("read data wrong");
endmodule

bind rfat_bank rfat_bank_checker #(.WIDTH(WIDTH)) u_chk (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
   .I_ENABLE(I_ENABLE), .I_SOFT_RESET(I_SOFT_RESET), .I_ADDR(I_ADDR), .I_READ(I_READ),
   .I_WRITE(I_WRITE), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .I_HW_VALUE(I_HW_VALUE),
   .I_HW_SET(I_HW_SET), .O_FIELDS(O_FIELDS));

// ===== tb/rfat_bank_test.sv
// Self-checking bench for the register field bank
`timescale 1ns/10ps
module rfat_bank_test;
   logic        clk = 1'b0, nrst = 1'b0, en = 1'b1, srst = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, hwv = 8'h00, hws = 8'h00, rdata;
   logic [95:0] fields;
   int          n_errors = 0, num_checks = 0;
   always #2.5 clk = ~clk;
   rfat_bank u_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_ENABLE(en), .I_SOFT_RESET(srst),
      .I_ADDR(addr), .I_READ(rd), .I_WRITE(wr), .I_WDATA(wdata), .O_RDATA(rdata),
      .I_HW_VALUE(hwv), .I_HW_SET(hws), .O_FIELDS(fields));
   function automatic logic [7:0] fld(input int g);
      return fields[g*8+:8];
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One strobe cycle from a falling edge; the next call sets the strobes anew,
   // so no signal is driven twice in one time step
   task automatic op(input logic [3:0] a, input logic r, input logic w, input logic [7:0] d);
      addr = a; rd = r; wr = w; wdata = d;
      @(negedge clk);
   endtask
   task automatic s_basic();
      hwv = 8'h5A; op(4'h0, 1'b0, 1'b1, 8'hFF);
      op(4'h0, 1'b1, 1'b0, 8'h00); check("ro", rdata, 8'h5A);
      op(4'h1, 1'b1, 1'b0, 8'h00); check("sor", fld(1), 8'hFF);
      op(4'h2, 1'b0, 1'b1, 8'h3C); check("wo", fld(2), 8'h3C);
      op(4'h3, 1'b0, 1'b1, 8'h81); op(4'h3, 1'b0, 1'b1, 8'h18);
      op(4'h3, 1'b1, 1'b0, 8'h00); check("w1s", rdata, 8'h99);
      op(4'hB, 1'b0, 1'b1, 8'h00); check("rsv", fld(11), 8'h00);
      op(4'hB, 1'b1, 1'b0, 8'h00);
   endtask
   task automatic s_clear();
      hws = 8'hF0; op(4'h4, 1'b0, 1'b1, 8'h30); check("w1c race", fld(4), 8'hF0);
      hws = 8'h44; op(4'h4, 1'b0, 1'b1, 8'h10); check("w1c", fld(4), 8'hE4);
      hws = 8'h00; op(4'h5, 1'b0, 1'b1, 8'h00); check("wc", fld(5), 8'h00);
      op(4'h7, 1'b1, 1'b0, 8'h00);
      hws = 8'h21; op(4'h7, 1'b0, 1'b0, 8'h00); hws = 8'h00;
      op(4'h7, 1'b1, 1'b0, 8'h00); check("lh read", rdata, 8'h21);
      check("lh clr", fld(7), 8'h00);
      hwv = 8'hFF; op(4'h6, 1'b1, 1'b0, 8'h00);
      hwv = 8'hFE; op(4'h6, 1'b0, 1'b0, 8'h00); hwv = 8'hFF;
      check("ll set", fld(6), 8'h01);
      op(4'h6, 1'b1, 1'b0, 8'h00); check("ll clr", fld(6), 8'h00);
      check("ll read", rdata, 8'hFE);
   endtask
   task automatic s_sticky();
      op(4'h8, 1'b0, 1'b1, 8'h06); check("sc set", fld(8), 8'h06);
      op(4'h8, 1'b0, 1'b0, 8'h00); check("sc clr", fld(8), 8'h00);
      hwv = 8'h00; op(4'h9, 1'b1, 1'b0, 8'h00);
      hwv = 8'h08; op(4'h9, 1'b0, 1'b0, 8'h00); hwv = 8'h00;
      op(4'h9, 1'b0, 1'b0, 8'h00); check("sticky hold", fld(9), 8'h08);
      hwv = 8'h08; op(4'h9, 1'b1, 1'b0, 8'h00); check("sticky rd", fld(9), 8'h08);
      hwv = 8'h00; op(4'h9, 1'b0, 1'b0, 8'h00); check("sticky drop", fld(9), 8'h00);
   endtask
   task automatic s_soft();
      op(4'hA, 1'b0, 1'b1, 8'hA5);
      srst = 1'b1; op(4'hA, 1'b0, 1'b0, 8'h00); srst = 1'b0;
      check("immune", fld(10), 8'hA5);
      check("soft clr", fld(3), 8'h00);
      // Clock enable low must keep a strobe from being taken
      en = 1'b0; op(4'h3, 1'b0, 1'b1, 8'hFF); en = 1'b1;
      check("frozen", fld(3), 8'h00);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      s_basic();
      s_clear();
      s_sticky();
      s_soft();
      results();
   end
endmodule

// ===== verilog/rfat_bank.sv
// Bank of register field cells, one of each access type, with a host port
//
// Behaviour
// R01 - Read-only fields show their live value and ignore host writes.
// R02 - Set-on-read fields become set when the host reads them.
// R03 - Write-only fields take writes and read back a value nobody may rely on.
// R04 - Write-one-to-set fields set each bit written as one and keep the others.
// R05 - Write-one-to-clear fields clear each bit written as one and keep the others.
// R06 - Write-anything-to-clear fields clear on any host write.
// R07 - Latch-low and latch-high fields clear when the host reads their register.
// R08 - Auto-clearing bits fall back by themselves, ignore zero writes and stay readable.
// R09 - A sticky high status bit stays high until it has been read.
// R10 - After a read the sticky bit follows its condition and drops once it is gone.
// R11 - An unread sticky bit holds high even when its condition goes away.
// R12 - Soft-reset immune fields keep their values on a software reset.
// R13 - Software writes zeros to reserved fields.
// R14 - Software does not rely on reserved bits read back.
// R15 - Read and write side effects happen in the cycle of the strobe.
// R16 - A hardware set beats a host clear in the same cycle.
`timescale 1ns/10ps
module rfat_bank
   import rfat_pkg::*;
#(
   parameter int WIDTH = RFAT_FIELD_WIDTH
)
(
   // Clock, reset, enable
   input  wire logic                                   I_CLOCK,
   input  wire logic                                   I_NRST,
   input  wire logic                                   I_ENABLE,
   input  wire logic                                   I_SOFT_RESET,
   // Host register port, one-cycle strobes
   input  wire logic [3:0]                             I_ADDR,
   input  wire logic                                   I_READ,
   input  wire logic                                   I_WRITE,
   input  wire logic [WIDTH-1:0]                       I_WDATA,
   output logic      [WIDTH-1:0]                       O_RDATA,
   // Hardware conditions, from logic on this clock
   input  wire logic [WIDTH-1:0]                       I_HW_VALUE,
   input  wire logic [WIDTH-1:0]                       I_HW_SET,
   // Field contents toward the device logic
   output logic      [rfat_pkg::RFAT_NUM_FIELDS*WIDTH-1:0] O_FIELDS
);
   import rfat_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic [RFAT_NUM_FIELDS-1:0]       sel;
   logic [WIDTH-1:0]                 rd [RFAT_NUM_FIELDS];
   logic [WIDTH-1:0]                 next_rdata;
   logic [WIDTH-1:0]                 rdata;

   genvar g;
   generate
      for (g = 0; g < RFAT_NUM_FIELDS; g++)
      begin : gen_field
         assign sel[g] = (I_ADDR == 4'(g));
         rfat_field
         #(
            .ACCESS    (rfat_access_type'(g)),
            .WIDTH     (WIDTH),
            .RESET_VAL (RFAT_RESET_VALUE[WIDTH-1:0]),
            // The plain read-write cell stands in as the immune control field
            .SR_IMMUNE (g == int'(RFAT_READ_WRITE))
         )
         u_field
         (
            .i_clock      (I_CLOCK),
            .i_nrst       (I_NRST),
            .i_enable     (I_ENABLE),
            .i_soft_reset (I_SOFT_RESET),
            .i_read       (I_READ && sel[g]),  // R15
            .i_write      (I_WRITE && sel[g]), // R15
            .i_wdata      (I_WDATA),
            .i_hw_value   (I_HW_VALUE),
            .i_hw_set     (I_HW_SET),
            .o_rdata      (rd[g]),
            .o_value      (O_FIELDS[g*WIDTH +: WIDTH])
         );
      end
   endgenerate

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Unmapped addresses read zero; data is captured before read side effects land
   always_comb
   begin
      next_rdata = rdata;
      if (I_READ)
      begin
         next_rdata = '0;
         for (int i = 0; i < RFAT_NUM_FIELDS; i++)
         begin
            if (sel[i])
            begin
               next_rdata = rd[i];
            end
         end
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         rdata <= '0;
      end
      else if (I_ENABLE)
      begin
         rdata <= next_rdata;
      end
   end

   assign O_RDATA = rdata;

endmodule

// ===== verilog/rfat_field.sv
// One register field cell of a selectable access type
`timescale 1ns/10ps
module rfat_field
   import rfat_pkg::*;
#(
   parameter rfat_access_type ACCESS     = RFAT_READ_WRITE,
   parameter int              WIDTH      = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0,
   parameter bit              SR_IMMUNE  = 1'b0
)
(
   // Clock and resets
   input  wire logic             i_clock,
   input  wire logic             i_nrst,
   input  wire logic             i_enable,
   input  wire logic             i_soft_reset,
   // Host access, one-cycle strobes
   input  wire logic             i_read,
   input  wire logic             i_write,
   input  wire logic [WIDTH-1:0] i_wdata,
   // Hardware side
   input  wire logic [WIDTH-1:0] i_hw_value,
   input  wire logic [WIDTH-1:0] i_hw_set,
   // Outputs
   output logic      [WIDTH-1:0] o_rdata,
   output logic      [WIDTH-1:0] o_value
);

   logic [WIDTH-1:0] stored;
   logic [WIDTH-1:0] next_stored;
   logic [WIDTH-1:0] unread;
   logic [WIDTH-1:0] next_unread;
   logic             soft_clear;

   assign soft_clear = i_soft_reset && !SR_IMMUNE; // R12

   // ----------------------------------------
   // Next value per access type
   // ----------------------------------------
   always_comb
   begin
      next_stored = stored;
      next_unread = unread;
      case (ACCESS)
         RFAT_READ_ONLY:
            next_stored = i_hw_value; // R01
         RFAT_SET_ON_READ:
            next_stored = i_read ? {WIDTH{1'b1}} : stored; // R02 R15
         RFAT_WRITE_ONLY:
            next_stored = i_write ? i_wdata : stored; // R03
         RFAT_WRITE_ONE_SET:
            next_stored = i_write ? (stored | i_wdata) : stored; // R04 R15
         RFAT_WRITE_ONE_CLEAR:
            next_stored = (i_write ? (stored & ~i_wdata) : stored) | i_hw_set; // R05 R16
         RFAT_WRITE_ANY_CLEAR:
            next_stored = (i_write ? '0 : stored) | i_hw_set; // R06 R16
         RFAT_LATCH_HIGH_CLR_READ:
            next_stored = (i_read ? '0 : stored) | i_hw_set; // R07 R15 R16
         RFAT_LATCH_LOW_CLR_READ:
            // Stored as a 1 for "went low"; the read view is inverted
            next_stored = (i_read ? '0 : stored) | ~i_hw_value; // R07 R16
         RFAT_AUTO_CLEARING:
            // Set lasts exactly one cycle; zeros written do nothing
            next_stored = i_write ? i_wdata : '0; // R08
         RFAT_STICKY_HIGH_STATUS:
         begin
            // Latch only on a fresh rise, so a bit already read follows its condition
            next_unread = (i_read ? '0 : unread) | (i_hw_value & ~stored); // R09 R11 R16
            next_stored = i_hw_value | next_unread; // R10 R11
         end
         RFAT_READ_WRITE:
            next_stored = i_write ? i_wdata : stored;
         default:
            next_stored = '0; // R13 R14
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         stored <= RESET_VAL;
         unread <= '0;
      end
      else if (i_enable)
      begin
         if (soft_clear)
         begin
            stored <= RESET_VAL; // R12
            unread <= '0;
         end
         else
         begin
            stored <= next_stored;
            unread <= next_unread;
         end
      end
   end

   // ----------------------------------------
   // Read view
   // ----------------------------------------
   // Write-only reads a fixed value; software must not rely on it
   assign o_rdata = (ACCESS == RFAT_WRITE_ONLY) ? RFAT_WO_READ[WIDTH-1:0] : // R03
                    (ACCESS == RFAT_RESERVED) ? '0 :
                    (ACCESS == RFAT_LATCH_LOW_CLR_READ) ? ~stored : stored;
   assign o_value = stored;

endmodule

// ===== verilog/rfat_pkg.sv
// Package: access types, widths and reset values for the register field cells
package rfat_pkg;

   // ----------------------------------------
   // Access type encoding
   // ----------------------------------------
   typedef enum logic [3:0]
   {
      RFAT_READ_ONLY            = 4'h0,
      RFAT_SET_ON_READ          = 4'h1,
      RFAT_WRITE_ONLY           = 4'h2,
      RFAT_WRITE_ONE_SET        = 4'h3,
      RFAT_WRITE_ONE_CLEAR      = 4'h4,
      RFAT_WRITE_ANY_CLEAR      = 4'h5,
      RFAT_LATCH_LOW_CLR_READ   = 4'h6,
      RFAT_LATCH_HIGH_CLR_READ  = 4'h7,
      RFAT_AUTO_CLEARING        = 4'h8,
      RFAT_STICKY_HIGH_STATUS   = 4'h9,
      RFAT_READ_WRITE           = 4'hA,
      RFAT_RESERVED             = 4'hB
   } rfat_access_type;

   // ----------------------------------------
   // Sizes and reset values
   // ----------------------------------------
   localparam int          RFAT_NUM_FIELDS  = 12;
   localparam int          RFAT_FIELD_WIDTH = 8;
   localparam logic [7:0]  RFAT_RESET_VALUE = 8'h00;
   localparam logic [7:0]  RFAT_WO_READ     = 8'h00;

endpackage
